// ===== hw/aiseq_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the sequencer
// Assumes: 16-bit host bus, word addressing of the instruction store
// Notes: Definitions only
`ifndef AISEQ_MAP_SVH
`define AISEQ_MAP_SVH

// ----------------------------------------------------------------
// Host addresses (A4..A1)
// ----------------------------------------------------------------
`define AISEQ_ADDR_CFG 4'h8
`define AISEQ_ADDR_TMR 4'hb
`define AISEQ_ADDR_STAT 4'ha

// ----------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------
`define AISEQ_CFG_START 0
`define AISEQ_CFG_RESET 1
`define AISEQ_CFG_IOSEL 7
`define AISEQ_CFG_PTR_LO 8
`define AISEQ_CFG_RST_VAL 16'h0000

// ----------------------------------------------------------------
// First instruction section fields
// ----------------------------------------------------------------
`define AISEQ_I_LOOP 0
`define AISEQ_I_PAUSE 1
`define AISEQ_I_POS_LO 2
`define AISEQ_I_NEG_LO 5
`define AISEQ_I_SYNC 8
`define AISEQ_I_TIMER 9
`define AISEQ_I_RES8 10
`define AISEQ_I_WDOG 11
`define AISEQ_I_ACQ_LO 12

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define AISEQ_ACQ_BASE_NS 16
`define AISEQ_CLK_NS 8
`define AISEQ_ACQ_BASE_CYC ((`AISEQ_ACQ_BASE_NS + `AISEQ_CLK_NS - 1) / `AISEQ_CLK_NS)

`endif

// ===== hw/aiseq_pkg.sv
// Purpose: Types of the instruction sequencer
// Assumes: Constants live in aiseq_map.svh
// Notes: None
package aiseq_pkg;

    typedef enum logic [2:0] {
        AISEQ_IDLE = 3'b000,
        AISEQ_FETCH = 3'b001,
        AISEQ_HOLD = 3'b010,
        AISEQ_ACQ = 3'b011,
        AISEQ_SYNC = 3'b100,
        AISEQ_TIMER = 3'b101,
        AISEQ_CONV = 3'b110
    } aiseq_state_t;

    typedef struct packed {
        logic [3:0] acq_time;
        logic wdog;
        logic res8;
        logic timer;
        logic sync;
        logic [2:0] neg_sel;
        logic [2:0] pos_sel;
        logic pause;
        logic loop;
    } aiseq_instr_t;

    typedef struct packed {
        logic [2:0] pos_sel;
        logic [2:0] neg_sel;
        logic neg_gnd;
        logic res8;
        logic wdog;
        logic limit2;
    } aiseq_conv_t;

endpackage

// ===== hw/aiseq_top.sv
// Purpose: Instruction store, sequencer and first-section decode of the converter
// Assumes: Host bus synchronous to clk; converter reports done with conv_done
// Notes: Contract list below
//
// Contract
// - Loop flag makes next fetch instruction zero
// - Pause halts before execute, clears start
// - Pause halt pulses pause interrupt source
// - Writing start one resumes after pause
// - After soft reset decode zero, await start
// - First instruction zero ignores pause flag
// - Wrap to zero, pause now halts
// - Bits 2-4 select non-inverting input
// - Bits 5-7 select inverting, 000 ground
// - Sync bit waits trigger rising edge
// - Watchdog sync needs two trigger edges
// - Timer bit waits down-counter zero, no conversion
// - Bit 10 picks 8 or 12 bit
// - Bit 11 picks two comparisons or conversion
// - 48-bit instructions, three sections via pointer
// - Bits 12-15 set acquisition time
`timescale 1ns/1ps
`include "aiseq_map.svh"

module aiseq_top #(
    parameter int DEPTH = 8
) (
    input wire logic clk, // Converter clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic [3:0] bus_addr, // Word address A4..A1
    input wire logic bus_wr, // Write strobe
    input wire logic bus_rd, // Read strobe
    input wire logic [15:0] bus_wdata, // Write data
    output logic [15:0] bus_rdata, // Read data
    input wire logic sync_in, // Trigger pin level
    input wire logic conv_done, // Conversion or comparison finished
    output logic conv_go, // Start a conversion pulse
    output aiseq_pkg::aiseq_conv_t conv_cfg, // Settings of the running step
    output logic acq_active, // Sample-and-hold acquiring
    output logic pause_irq, // Pause interrupt source pulse
    output logic [2:0] seq_addr, // Instruction being executed
    output logic seq_running // Start bit state
);

    localparam int AW = $clog2(DEPTH);

    logic [15:0] ram_r [DEPTH][3];
    logic [15:0] cfg_r;
    logic [15:0] tmr_preset_r;
    logic [15:0] tmr_cnt_r;
    logic [AW-1:0] pc_r;
    logic first_r;
    logic paused_r;
    logic limit2_r;
    logic sync_d_r;
    logic [6:0] acq_cnt_r;
    aiseq_pkg::aiseq_state_t st_r;
    aiseq_pkg::aiseq_state_t st_nxt;

    // ----------------------------------------------------------------
    // Host decode
    // ----------------------------------------------------------------
    wire [1:0] ptr = cfg_r[`AISEQ_CFG_PTR_LO +: 2];
    wire ram_hit = (bus_addr[3] == 1'b0) && (int'(bus_addr[2:0]) < DEPTH) && (ptr != 2'b11);
    wire cfg_wr = bus_wr && (bus_addr == `AISEQ_ADDR_CFG);
    wire tmr_wr = bus_wr && (bus_addr == `AISEQ_ADDR_TMR);
    wire soft_rst = cfg_wr && bus_wdata[`AISEQ_CFG_RESET];
    wire start = cfg_r[`AISEQ_CFG_START];
    wire sync_rise = sync_in && !sync_d_r && !cfg_r[`AISEQ_CFG_IOSEL];
    aiseq_pkg::aiseq_instr_t ins;
    assign ins = ram_r[pc_r][0];
    wire last = ins.loop || (pc_r == AW'(DEPTH - 1));
    // Pause acts once per visit, so a later start write resumes
    wire pause_hit = (st_r == aiseq_pkg::AISEQ_HOLD) && ins.pause && !first_r &&
        !paused_r;
    wire [6:0] acq_len = 7'(`AISEQ_ACQ_BASE_CYC) + {1'b0, ins.acq_time, 2'b00};
    wire [15:0] rd_mux = (bus_addr == `AISEQ_ADDR_CFG) ? cfg_r :
        (bus_addr == `AISEQ_ADDR_TMR) ? tmr_preset_r :
        (bus_addr == `AISEQ_ADDR_STAT) ? {13'h0000, 3'(pc_r)} :
        ram_hit ? ram_r[bus_addr[AW-1:0]][ptr] : 16'h0000;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            aiseq_pkg::AISEQ_IDLE: st_nxt = aiseq_pkg::AISEQ_IDLE;
            aiseq_pkg::AISEQ_FETCH: st_nxt = aiseq_pkg::AISEQ_HOLD;
            aiseq_pkg::AISEQ_HOLD: begin
                if (start && !pause_hit) begin
                    st_nxt = ins.timer ? aiseq_pkg::AISEQ_TIMER : aiseq_pkg::AISEQ_ACQ;
                end
            end
            aiseq_pkg::AISEQ_TIMER: begin
                if (tmr_cnt_r == 16'h0000) begin
                    st_nxt = aiseq_pkg::AISEQ_FETCH;
                end
            end
            aiseq_pkg::AISEQ_ACQ: begin
                if (acq_cnt_r == 7'h00) begin
                    st_nxt = ins.sync ? aiseq_pkg::AISEQ_SYNC : aiseq_pkg::AISEQ_CONV;
                end
            end
            aiseq_pkg::AISEQ_SYNC: begin
                if (sync_rise) begin
                    st_nxt = aiseq_pkg::AISEQ_CONV;
                end
            end
            aiseq_pkg::AISEQ_CONV: begin
                if (conv_done) begin
                    if (ins.wdog && !limit2_r) begin
                        st_nxt = ins.sync ? aiseq_pkg::AISEQ_SYNC : aiseq_pkg::AISEQ_CONV;
                    end else begin
                        st_nxt = aiseq_pkg::AISEQ_FETCH;
                    end
                end
            end
            default: st_nxt = aiseq_pkg::AISEQ_IDLE;
        endcase
    end

    wire step_done = (st_r != aiseq_pkg::AISEQ_FETCH) && (st_nxt == aiseq_pkg::AISEQ_FETCH);
    wire go_nxt = (st_nxt == aiseq_pkg::AISEQ_CONV) &&
        ((st_r != aiseq_pkg::AISEQ_CONV) || conv_done);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= aiseq_pkg::AISEQ_IDLE;
            pc_r <= '0;
            first_r <= 1'b1;
            paused_r <= 1'b0;
        end else if (soft_rst) begin
            st_r <= aiseq_pkg::AISEQ_FETCH;
            pc_r <= '0;
            first_r <= 1'b1;
            paused_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (pause_hit) begin
                paused_r <= 1'b1;
            end else if (step_done) begin
                paused_r <= 1'b0;
            end
            if (step_done) begin
                pc_r <= last ? '0 : pc_r + 1'b1;
                first_r <= 1'b0;
            end
        end
    end

    // Watchdog limit phase and trigger history
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            limit2_r <= 1'b0;
            sync_d_r <= 1'b0;
        end else begin
            sync_d_r <= sync_in;
            if (st_r == aiseq_pkg::AISEQ_CONV && conv_done) begin
                limit2_r <= ins.wdog && !limit2_r;
            end else if (st_r == aiseq_pkg::AISEQ_FETCH) begin
                limit2_r <= 1'b0;
            end
        end
    end

    // Acquisition and timer counters
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            acq_cnt_r <= 7'h00;
            tmr_cnt_r <= 16'h0000;
        end else begin
            acq_cnt_r <= (st_nxt == aiseq_pkg::AISEQ_ACQ && st_r != aiseq_pkg::AISEQ_ACQ) ?
                acq_len - 7'h01 : (acq_cnt_r != 7'h00 ? acq_cnt_r - 7'h01 : 7'h00);
            if (st_nxt == aiseq_pkg::AISEQ_TIMER && st_r != aiseq_pkg::AISEQ_TIMER) begin
                tmr_cnt_r <= tmr_preset_r;
            end else if (tmr_cnt_r != 16'h0000) begin
                tmr_cnt_r <= tmr_cnt_r - 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Host registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg_r <= `AISEQ_CFG_RST_VAL;
            tmr_preset_r <= 16'h0000;
        end else begin
            if (cfg_wr) begin
                cfg_r <= bus_wdata & ~(16'h0001 << `AISEQ_CFG_RESET);
            end else if (pause_hit) begin
                cfg_r[`AISEQ_CFG_START] <= 1'b0;
            end
            if (tmr_wr) begin
                tmr_preset_r <= bus_wdata;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH * 3; gi++) begin : g_ram
            always_ff @(posedge clk) begin
                if (bus_wr && ram_hit && bus_addr[AW-1:0] == AW'(gi / 3) &&
                    ptr == 2'(gi % 3)) begin
                    ram_r[gi / 3][gi % 3] <= bus_wdata;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bus_rdata <= 16'h0000;
            conv_go <= 1'b0;
            conv_cfg <= '0;
            acq_active <= 1'b0;
            pause_irq <= 1'b0;
            seq_addr <= 3'h0;
            seq_running <= 1'b0;
        end else begin
            bus_rdata <= bus_rd ? rd_mux : bus_rdata;
            conv_go <= go_nxt && !soft_rst;
            conv_cfg.pos_sel <= ins.pos_sel;
            conv_cfg.neg_sel <= ins.neg_sel;
            conv_cfg.neg_gnd <= (ins.neg_sel == 3'h0);
            conv_cfg.res8 <= ins.res8;
            conv_cfg.wdog <= ins.wdog;
            conv_cfg.limit2 <= (st_r == aiseq_pkg::AISEQ_CONV && conv_done) ?
                (ins.wdog && !limit2_r) : limit2_r;
            acq_active <= (st_nxt == aiseq_pkg::AISEQ_ACQ);
            pause_irq <= pause_hit && start;
            seq_addr <= 3'(pc_r);
            // Mirrors the start bit as it will stand after this edge
            seq_running <= cfg_wr ? bus_wdata[`AISEQ_CFG_START] : (start && !pause_hit);
        end
    end

endmodule

// ===== verification/aiseq_conv_model.sv
// Purpose: Converter answering each start pulse
// Assumes: One conversion at a time
// Notes: Busy time is a plain parameter
`timescale 1ns/1ps
module aiseq_conv_model #(
    parameter int BUSY = 5
) (
    input wire logic clk, // Clock
    input wire logic conv_go, // Start pulse
    output logic conv_done // Finished pulse
);
    int cnt = 0;
    initial conv_done = 1'b0;
    always @(posedge clk) begin
        conv_done <= (cnt == 1);
        if (conv_go === 1'b1)
            cnt <= BUSY;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule

// ===== verification/aiseq_top_assertions.sv
// Purpose: Port assertions of the sequencer
// Assumes: Bound to aiseq_top
// Notes: Sync reset masks all checks
`timescale 1ns/1ps
module aiseq_top_assertions (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic conv_go, // Start pulse
    input wire aiseq_pkg::aiseq_conv_t conv_cfg, // Step settings
    input wire logic acq_active, // Acquiring
    input wire logic pause_irq, // Pause pulse
    input wire logic seq_running // Start bit
);
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_irq_single: assert property (pause_irq |=> !pause_irq)
        else $error("pause pulse too long");
    chk_pause_stop: assert property (pause_irq |-> !seq_running ##1 (!acq_active && !conv_go))
        else $error("pause did not halt");
    chk_go_single: assert property (conv_go |=> !conv_go)
        else $error("start pulse too long");
    chk_gnd_decode: assert property (conv_go |-> conv_cfg.neg_gnd == (conv_cfg.neg_sel == 3'h0))
        else $error("ground select wrong");
    chk_limit_pair: assert property (conv_go && conv_cfg.limit2 |-> conv_cfg.wdog)
        else $error("second limit outside window mode");
    chk_acq_no_go: assert property (acq_active |-> !conv_go)
        else $error("start during acquisition");
    chk_cfg_steady: assert property (acq_active && $past(acq_active) |-> $stable(conv_cfg))
        else $error("settings moved in acquisition");
    chk_reset_idle: assert property ($rose(rst_b) |-> !seq_running && !acq_active)
        else $error("not idle after reset");
endmodule
bind aiseq_top aiseq_top_assertions aiseq_top_assertions_inst (
    .clk(clk), .rst_b(rst_b), .conv_go(conv_go), .conv_cfg(conv_cfg),
    .acq_active(acq_active), .pause_irq(pause_irq), .seq_running(seq_running));

// ===== verification/aiseq_top_tb.sv
// Purpose: Self-checking bench of the sequencer
// Assumes: Converter model answers every start
// Notes: Host side driven by bus tasks
`timescale 1ns/1ps
`include "aiseq_map.svh"
module aiseq_top_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] bus_addr = 4'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [15:0] bus_wdata = 16'h0000;
    logic [15:0] bus_rdata;
    logic sync_in = 1'b0;
    logic conv_done;
    logic conv_go;
    aiseq_pkg::aiseq_conv_t conv_cfg;
    logic acq_active;
    logic pause_irq;
    logic [2:0] seq_addr;
    logic seq_running;
    int miscompares = 0;
    int checks_done = 0;
    int n_go = 0;
    int base;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (conv_go === 1'b1)
            n_go <= n_go + 1;
    end
    aiseq_top aiseq_top_inst (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .sync_in(sync_in),
        .conv_done(conv_done), .conv_go(conv_go), .conv_cfg(conv_cfg),
        .acq_active(acq_active), .pause_irq(pause_irq), .seq_addr(seq_addr),
        .seq_running(seq_running));
    aiseq_conv_model aiseq_conv_model_inst (.clk(clk), .conv_go(conv_go), .conv_done(conv_done));
    // ----------------------------------------------------------------
    // Host tasks
    // ----------------------------------------------------------------
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        cmp(bus_rdata, e);
    endtask
    function automatic logic [9:0] ecfg(input logic [2:0] p, n, f);
        return {p, n, n == 3'h0, f};
    endfunction
    task automatic wait_go(input logic [9:0] e, input int acq);
        int i;
        int n;
        i = 0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            if (acq_active === 1'b1)
                n++;
            i++;
        end while (conv_go !== 1'b1 && i < 500);
        cmp({5'h00, conv_go, conv_cfg}, {6'h01, e});
        if (acq >= 0)
            cmp(16'(n), 16'(acq));
    endtask
    task automatic trig();
        @(posedge clk);
        sync_in <= 1'b0;
        repeat (20) @(posedge clk);
        sync_in <= 1'b1;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        // Pause and acq 2 at step 0; 8-bit, loop, acq 1 at step 1
        wr(4'h0, 16'h200e);
        wr(4'h1, 16'h1455);
        wr(`AISEQ_ADDR_CFG, 16'h0100);
        wr(4'h1, 16'h00a5);
        rd(4'h1, 16'h00a5);
        wr(`AISEQ_ADDR_CFG, 16'h0300);
        rd(4'h1, 16'h0000);
        wr(`AISEQ_ADDR_CFG, 16'h0002);
        repeat (10) @(posedge clk);
        cmp({15'h0, acq_active}, 16'h0);
        wr(`AISEQ_ADDR_CFG, 16'h0001);
        wait_go(ecfg(3'h3, 3'h0, 3'h0), 10);
        wait_go(ecfg(3'h5, 3'h2, 3'h4), 6);
        for (int i = 0; i < 200 && pause_irq !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        cmp({pause_irq, seq_running, 11'h0, seq_addr}, 16'h8000);
        base = n_go;
        repeat (20) @(posedge clk);
        cmp(16'(n_go - base), 16'h0);
        wr(`AISEQ_ADDR_CFG, 16'h0001);
        wait_go(ecfg(3'h3, 3'h0, 3'h0), 10);
        wr(`AISEQ_ADDR_CFG, 16'h0000);
        repeat (40) @(posedge clk);
        // Window mode with trigger wait, channels 7 and 7
        wr(4'h0, 16'h09fd);
        wr(`AISEQ_ADDR_CFG, 16'h0002);
        wr(`AISEQ_ADDR_CFG, 16'h0081);
        base = n_go;
        trig();
        repeat (20) @(posedge clk);
        cmp(16'(n_go - base), 16'h0);
        sync_in <= 1'b0;
        wr(`AISEQ_ADDR_CFG, 16'h0001);
        trig();
        wait_go(ecfg(3'h7, 3'h7, 3'h2), -1);
        trig();
        wait_go(ecfg(3'h7, 3'h7, 3'h3), -1);
        wr(`AISEQ_ADDR_CFG, 16'h0000);
        repeat (10) @(posedge clk);
        // Timer wait at step 0, then step 1 converts
        wr(4'h0, 16'h0200);
        wr(`AISEQ_ADDR_TMR, 16'h0014);
        wr(`AISEQ_ADDR_CFG, 16'h0002);
        wr(`AISEQ_ADDR_CFG, 16'h0001);
        base = n_go;
        repeat (15) @(posedge clk);
        cmp({n_go == base, seq_running, 14'h0}, 16'hc000);
        wait_go(ecfg(3'h5, 3'h2, 3'h4), 6);
        final_report();
    end
endmodule
